// file: verilog/usb_ep_consts.vh
// constants for the usb device port endpoint control block
`ifndef USB_EP_CONSTS_VH
`define USB_EP_CONSTS_VH
// ******************************
// register byte addresses
// ******************************
`define CSR_BASE      12'h030
`define FIFO_BASE     12'h050
`define TXV_ADDR      12'h074
`define EPRST_ADDR    12'h028
`define IRQ_ADDR      12'h01C
// ******************************
// control/status field positions
// ******************************
`define B_TX_COMPLETE      0
`define B_RXBK0       1
`define B_SETUP       2
`define B_STALL       3
`define B_TXRDY       4
`define B_FSTALL      5
`define B_RXBK1       6
`define B_DIR         7
`define B_TYPE_LO     8
`define B_TYPE_HI     10
`define B_TOGGLE      11
`define B_ENABLE      15
`define B_CNT_LO      16
`define B_CNT_HI      26
`define B_TRANSCEIVER_DISABLE      8
// ******************************
// endpoint types and sizes
// ******************************
`define TYPE_CTRL     3'h0
`define TYPE_ISO_OUT  3'h1
`define FIFO_DEPTH    64
`define FIFO_AW       6
`define NUM_EP        4
`endif

// file: verilog/ep_fifo.v
// single 64 byte fifo shared by receive and transmit data for one endpoint
`timescale 1ns/1ps
module ep_fifo (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clr,      // endpoint reset: pointers to zero
  input  wire        wr_en,    // push one byte
  input  wire [7:0]  wr_data,
  input  wire        rd_en,    // pop one byte
  output reg  [7:0]  rd_data_ff,
  output wire [6:0]  level
);
`include "usb_ep_consts.vh"
  reg [7:0]          mem [0:`FIFO_DEPTH-1]; // byte storage
  reg [`FIFO_AW:0]   wp_ff;                 // write pointer
  reg [`FIFO_AW:0]   rp_ff;                 // read pointer
  assign level = wp_ff - rp_ff;
  // ******************************
  // pointers and storage
  // ******************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff      <= 7'h00;
      rp_ff      <= 7'h00;
      rd_data_ff <= 8'h00;
    end else if (clr) begin
      wp_ff <= 7'h00;
      rp_ff <= 7'h00;
    end else begin
      if (wr_en && level != `FIFO_DEPTH) begin
        wp_ff <= wp_ff + 7'h01;
      end
      if (rd_en && level != 7'h00) begin
        rd_data_ff <= mem[rp_ff[`FIFO_AW-1:0]];
        rp_ff      <= rp_ff + 7'h01;
      end
    end
  end
  // memory has no reset
  always @(posedge pclk) begin
    if (wr_en && !clr && level != `FIFO_DEPTH) begin
      mem[wp_ff[`FIFO_AW-1:0]] <= wr_data;
    end
  end
endmodule // ep_fifo

// file: verilog/usb_device_endpoint_ctrl.v
// endpoint control, status and fifo access for a usb device port
// Behaviour
// R1 - host ack of IN sets tx_complete, clear by 0
// R2 - packet in bank 0 sets rx_bank0_full
// R3 - firmware drains fifo then clears bank flag
// R4 - ping-pong packets use bank 1 flag
// R5 - valid setup sets setup_received, clear by 0
// R6 - OUT refused while setup_received set
// R7 - acked stall sets stall_acked, clear by 0
// R8 - iso endpoints: bit is crc error flag
// R9 - firmware sets tx_packet_ready, device clears
// R10 - force_stall_a write 1 answers STALL
// R11 - control direction bit gates data stage
// R12 - firmware sets direction before clearing setup
// R13 - three bit endpoint_type, top bit IN
// R14 - read-only data_toggle, DATA0/DATA1
// R15 - endpoint_enable bit read/write
// R16 - eleven bit read-only rx_byte_count
// R17 - fifo data register pops and pushes bytes
// R18 - firmware respects max packet size
// R19 - transceiver_disable powers down transceiver
// R20 - software enables clock before access
// R21 - endpoint reset clears pointers, count, toggle
// R22 - endpoint irq status sticky via flags
// R23 - irq is or of five flags
`timescale 1ns/1ps
module usb_device_endpoint_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // link side, one bit per endpoint except the received byte, tx_data and transceiver_disable
  input  wire [3:0]  sie_in_acked,     // host acked an IN packet
  input  wire [3:0]  sie_out_done,     // good OUT packet fully stored
  input  wire [3:0]  sie_setup_done,   // good setup packet stored
  input  wire [3:0]  sie_stall_acked,  // host acked our STALL
  input  wire [3:0]  sie_crc_error,    // crc error on iso packet
  input  wire [3:0]  sie_rx_wr,        // received byte strobe
  input  wire [7:0]  sie_rx_data,      // received byte
  input  wire [3:0]  sie_tx_rd,        // transmit byte pop strobe
  input  wire [3:0]  sie_toggle_flip,  // data toggle advances
  output wire [3:0]  out_accept,       // endpoint may take an OUT
  output wire [3:0]  in_ready,         // IN packet ready to send
  output wire [3:0]  stall_req,        // answer host with STALL
  output wire [31:0] tx_data,          // fifo byte per endpoint
  output wire [3:0]  ep_irq,           // per endpoint interrupt
  output wire        transceiver_disable
);
`include "usb_ep_consts.vh"
  // ******************************
  // bus decode
  // ******************************
  wire        wr     = psel & penable & pwrite;        // write strobe
  wire        rd     = psel & penable & ~pwrite;       // read strobe
  wire [1:0]  ep_sel = paddr[3:2];                     // endpoint index
  wire        csr_hit  = (paddr[11:4] == `CSR_BASE >> 4);
  wire        fifo_hit = (paddr[11:4] == `FIFO_BASE >> 4);
  wire        txv_hit  = (paddr == `TXV_ADDR);
  wire        rst_hit  = (paddr == `EPRST_ADDR);
  wire        irq_hit  = (paddr == `IRQ_ADDR);
  assign pready  = 1'b1;  // zero wait state slave
  assign pslverr = 1'b0;  // unmapped reads return zero
  reg         transceiver_disable_ff;                 // transceiver power down
  reg  [3:0]  eprst_ff;                  // endpoint reset bits
  assign transceiver_disable = transceiver_disable_ff; // R19
  // ******************************
  // per endpoint state
  // ******************************
  reg  [3:0]  tx_complete_ff;     // tx_complete
  reg  [3:0]  bk0_ff;        // rx_bank0_full
  reg  [3:0]  bk1_ff;        // rx_bank1_full
  reg  [3:0]  setup_ff;      // setup_received
  reg  [3:0]  stall_ff;      // stall_acked / iso_crc_error
  reg  [3:0]  txrdy_ff;      // tx_packet_ready
  reg  [3:0]  fstall_ff;     // force_stall_a
  reg  [3:0]  dir_ff;        // control direction
  reg  [3:0]  tog_ff;        // data_toggle
  reg  [3:0]  en_ff;         // endpoint_enable
  reg  [3:0]  nxt_bank_ff;   // bank for next OUT packet
  reg  [2:0]  type_ff [0:3]; // endpoint_type
  reg  [10:0] cnt_ff  [0:3]; // rx_byte_count
  wire [31:0] fifo_q;        // fifo output bytes
  wire [27:0] fifo_lvl;      // fifo levels
  wire [3:0]  fifo_pop;      // firmware or link pop
  wire [31:0] csr_rd [0:3];  // read view per endpoint

  genvar g;
  generate
    for (g = 0; g < `NUM_EP; g = g + 1) begin : g_ep
      wire csr_wr  = wr & csr_hit & (ep_sel == g);        // csr write
      wire fdr_wr  = wr & fifo_hit & (ep_sel == g);       // fifo push
      wire fdr_rd  = rd & fifo_hit & (ep_sel == g);       // fifo pop
      wire iso     = (type_ff[g][1:0] == 2'b01);          // R13
      wire ctrl    = (type_ff[g] == `TYPE_CTRL);          // R13
      wire is_in   = type_ff[g][2];                       // R13
      wire clr_bit = csr_wr;
      wire rx_bk1  = nxt_bank_ff[g] & (type_ff[g] != `TYPE_CTRL);
      assign fifo_pop[g] = fdr_rd | sie_tx_rd[g];         // R17
      // OUT accepted when enabled, no setup pending, no force stall, direction OUT and next bank free   R6 R11
      assign out_accept[g] = en_ff[g] & ~setup_ff[g] & ~fstall_ff[g] &
                             (ctrl ? ~dir_ff[g] : ~is_in) &
                             ~(rx_bk1 ? bk1_ff[g] : bk0_ff[g]);
      assign in_ready[g]  = en_ff[g] & txrdy_ff[g];       // R9
      assign stall_req[g] = fstall_ff[g];                 // R10
      assign ep_irq[g] = tx_complete_ff[g] | bk0_ff[g] | bk1_ff[g] |
                         setup_ff[g] | stall_ff[g];       // R23 R22
      assign csr_rd[g] = {5'h00, cnt_ff[g], en_ff[g], 3'h0, tog_ff[g],
                          type_ff[g], dir_ff[g], bk1_ff[g], 1'b0,
                          txrdy_ff[g], stall_ff[g], setup_ff[g],
                          bk0_ff[g], tx_complete_ff[g]};       // R14 R16
      ep_fifo u_fifo (
        .pclk       (pclk),
        .presetn    (presetn),
        .clr        (eprst_ff[g]),
        .wr_en      (fdr_wr | sie_rx_wr[g]),
        .wr_data    (fdr_wr ? pwdata[7:0] : sie_rx_data),
        .rd_en      (fifo_pop[g]),
        .rd_data_ff (fifo_q[8*g+7:8*g]),
        .level      (fifo_lvl[7*g+6:7*g])
      );
      assign tx_data[8*g+7:8*g] = fifo_q[8*g+7:8*g];
      // flags: hardware set wins over firmware clear
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_complete_ff[g]   <= 1'b0;
          bk0_ff[g]      <= 1'b0;
          bk1_ff[g]      <= 1'b0;
          setup_ff[g]    <= 1'b0;
          stall_ff[g]    <= 1'b0;
          txrdy_ff[g]    <= 1'b0;
          fstall_ff[g]   <= 1'b0;
          dir_ff[g]      <= 1'b0;
          en_ff[g]       <= 1'b0;
          tog_ff[g]      <= 1'b0;
          nxt_bank_ff[g] <= 1'b0;
          type_ff[g]     <= 3'h0;
          cnt_ff[g]      <= 11'h000;
        end else begin
          // tx_complete set on host ack               R1
          if (sie_in_acked[g])
            tx_complete_ff[g] <= 1'b1;
          else if (clr_bit && !pwdata[`B_TX_COMPLETE])
            tx_complete_ff[g] <= 1'b0;
          // bank 0 / bank 1 ping-pong                 R2 R4 R3
          if (sie_out_done[g] && !rx_bk1)
            bk0_ff[g] <= 1'b1;
          else if (clr_bit && !pwdata[`B_RXBK0])
            bk0_ff[g] <= 1'b0;
          if (sie_out_done[g] && rx_bk1)
            bk1_ff[g] <= 1'b1;
          else if (clr_bit && !pwdata[`B_RXBK1])
            bk1_ff[g] <= 1'b0;
          if (sie_out_done[g] && !ctrl)
            nxt_bank_ff[g] <= ~nxt_bank_ff[g];
          // setup received                            R5 R12
          if (sie_setup_done[g])
            setup_ff[g] <= 1'b1;
          else if (clr_bit && !pwdata[`B_SETUP])
            setup_ff[g] <= 1'b0;
          // stall ack or iso crc error                R7 R8
          if ((sie_stall_acked[g] && !iso) || (sie_crc_error[g] && iso))
            stall_ff[g] <= 1'b1;
          else if (clr_bit && !pwdata[`B_STALL])
            stall_ff[g] <= 1'b0;
          // firmware sets, host ack clears            R9
          if (sie_in_acked[g])
            txrdy_ff[g] <= 1'b0;
          else if (clr_bit && pwdata[`B_TXRDY])
            txrdy_ff[g] <= 1'b1;
          // force stall set by writing 1, released by setup received  R10
          if (clr_bit && pwdata[`B_FSTALL])
            fstall_ff[g] <= 1'b1;
          else if (sie_stall_acked[g] && !ctrl)
            fstall_ff[g] <= fstall_ff[g];
          else if (sie_setup_done[g])
            fstall_ff[g] <= 1'b0;
          // plain read/write fields                   R11 R13 R15
          if (clr_bit) begin
            dir_ff[g]  <= pwdata[`B_DIR];
            type_ff[g] <= pwdata[`B_TYPE_HI:`B_TYPE_LO];
            en_ff[g]   <= pwdata[`B_ENABLE];
          end
          // toggle and count                          R14 R16 R21
          if (eprst_ff[g]) begin
            tog_ff[g] <= 1'b0;
            cnt_ff[g] <= 11'h000;
          end else begin
            if (sie_toggle_flip[g])
              tog_ff[g] <= ~tog_ff[g];
            if (sie_out_done[g] || sie_setup_done[g])
              cnt_ff[g] <= {4'h0, fifo_lvl[7*g+6:7*g]};
            else if (fdr_rd && cnt_ff[g] != 11'h000)
              cnt_ff[g] <= cnt_ff[g] - 11'h001;
          end
        end
      end
    end
  endgenerate

  // ******************************
  // global registers
  // ******************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transceiver_disable_ff <= 1'b0;
      eprst_ff  <= 4'h0;
    end else begin
      if (wr && txv_hit)
        transceiver_disable_ff <= pwdata[`B_TRANSCEIVER_DISABLE]; // R19
      if (wr && rst_hit)
        eprst_ff <= pwdata[3:0];        // R21
    end
  end

  // ******************************
  // read mux
  // ******************************
  always @* begin
    prdata = 32'h00000000;
    if (rd && csr_hit)
      prdata = csr_rd[ep_sel];
    else if (rd && fifo_hit)
      prdata = {24'h000000, fifo_q[8*ep_sel +: 8]}; // R17
    else if (rd && txv_hit)
      prdata = {23'h000000, transceiver_disable_ff, 8'h00};
    else if (rd && rst_hit)
      prdata = {28'h0000000, eprst_ff};
    else if (rd && irq_hit)
      prdata = {28'h0000000, ep_irq};               // R22
  end
endmodule // usb_device_endpoint_ctrl

// file: dv/ep_ctrl_sva.sv
// assertion checker bound to the endpoint control block
`timescale 1ns/1ps
module ep_ctrl_sva (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [3:0]  sie_in_acked,
  input wire [3:0]  sie_out_done,
  input wire [3:0]  sie_setup_done,
  input wire [3:0]  sie_stall_acked,
  input wire [3:0]  sie_crc_error,
  input wire [3:0]  out_accept,
  input wire [3:0]  in_ready,
  input wire [3:0]  stall_req,
  input wire [3:0]  ep_irq,
  input wire        transceiver_disable
);
  // ******************************
  // helpers
  // ******************************
  wire wr = psel & penable & pwrite; // completed apb write
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // host takes a ready IN packet
  sequence s_in_ack;
    in_ready[0] && sie_in_acked[0];
  endsequence
  a_in_done: assert property (s_in_ack |=> ep_irq[0] && !in_ready[0])
    else $error("IN ack did not complete");
  a_rx_irq: assert property (out_accept[2] && sie_out_done[2] |=> ep_irq[2])
    else $error("rx packet gave no irq");
  a_setup_blk: assert property (sie_setup_done[0] |=> !out_accept[0])
    else $error("OUT accepted after setup");
  a_stall_irq: assert property (stall_req[0] && sie_stall_acked[0] |=> ep_irq[0])
    else $error("stall ack gave no irq");
  a_irq_sticky: assert property ($fell(ep_irq[0]) |-> $past(wr))
    else $error("irq dropped without write");
  a_irq_cause: assert property ($rose(ep_irq[0]) |-> $past(sie_in_acked[0] | sie_out_done[0] |
    sie_setup_done[0] | sie_stall_acked[0] | sie_crc_error[0]))
    else $error("irq rose without event");
  a_stall_set: assert property ($rose(stall_req[0]) |-> $past(wr))
    else $error("stall without write");
  a_txv_write: assert property ($changed(transceiver_disable) |-> $past(wr && paddr == 12'h074))
    else $error("transceiver bit moved alone");
  a_ready_clr: assert property ($fell(in_ready[0]) |-> $past(wr | sie_in_acked[0]))
    else $error("ready cleared without cause");
endmodule // ep_ctrl_sva
bind usb_device_endpoint_ctrl ep_ctrl_sva u_sva (.*);

// file: dv/sie_host_model.sv
// usb host side model driving the link strobes
`timescale 1ns/1ps
module sie_host_model (
  input  wire         pclk,
  input  wire  [3:0]  out_accept,
  input  wire  [3:0]  in_ready,
  input  wire  [31:0] tx_data,
  output logic [3:0]  sie_in_acked,
  output logic [3:0]  sie_out_done,
  output logic [3:0]  sie_setup_done,
  output logic [3:0]  sie_stall_acked,
  output logic [3:0]  sie_crc_error,
  output logic [3:0]  sie_rx_wr,
  output logic [7:0]  sie_rx_data,
  output logic [3:0]  sie_tx_rd,
  output logic [3:0]  sie_toggle_flip
);
  logic [7:0] rxq[$]; // bytes sent out
  logic [7:0] txq[$]; // bytes taken in
  initial {sie_in_acked, sie_out_done, sie_setup_done, sie_stall_acked, sie_crc_error,
           sie_rx_wr, sie_rx_data, sie_tx_rd, sie_toggle_flip} = '0;
  // one event pulse: 0 in ack, 1 out, 2 setup, 3 stall ack, 4 crc
  task automatic ev(input int k, input int ep);
    logic [3:0] b = 4'h1 << ep;
    case (k)
      0: sie_in_acked <= b;
      1: sie_out_done <= b;
      2: sie_setup_done <= b;
      3: sie_stall_acked <= b;
      default: sie_crc_error <= b;
    endcase
    sie_toggle_flip <= (k < 2) ? b : 4'h0;
    @(posedge pclk);
    {sie_in_acked, sie_out_done, sie_setup_done, sie_stall_acked, sie_crc_error, sie_toggle_flip} <= '0;
  endtask
  // data or setup packet; a refused OUT is a nak and sends nothing
  task automatic out_pkt(input int ep, input int n, input bit setup);
    logic [7:0] d;
    @(posedge pclk);
    if (!setup && !out_accept[ep]) return;
    rxq.delete();
    repeat (n) begin
      d = $urandom;
      rxq.push_back(d);
      sie_rx_wr <= 4'h1 << ep;
      sie_rx_data <= d;
      @(posedge pclk);
    end
    sie_rx_wr <= 4'h0;
    sie_rx_data <= ~d; // idle line carries no stale byte
    ev(setup ? 2 : 1, ep);
  endtask
  // pops n bytes then acknowledges the IN packet
  task automatic in_pkt(input int ep, input int n);
    txq.delete();
    repeat (n) begin
      sie_tx_rd <= 4'h1 << ep;
      @(posedge pclk);
      sie_tx_rd <= 4'h0;
      repeat (2) @(posedge pclk);
      txq.push_back(tx_data[8*ep+:8]);
    end
    ev(0, ep);
  endtask
endmodule // sie_host_model

// file: dv/tb_top.sv
// self-checking bench for the endpoint control block
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, transceiver_disable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, tx_data, r;
  logic [3:0]  sie_in_acked, sie_out_done, sie_setup_done, sie_stall_acked, sie_crc_error;
  logic [3:0]  sie_rx_wr, sie_tx_rd, sie_toggle_flip, out_accept, in_ready, stall_req, ep_irq;
  logic [7:0]  sie_rx_data;
  logic [7:0]  wq[$];   // bytes written for IN
  int fl[4], cf[4], tg[4], cn[4]; // expected flags, config, toggle, count
  int fails, comparisons;
  usb_device_endpoint_ctrl u_usb_device_endpoint_ctrl (.*);
  sie_host_model u_host (.*);
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer, read data left in r
  task automatic apb(input bit w, input int a, input int d);
    int i;
    psel <= 1; pwrite <= w; paddr <= a[11:0]; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    if (i == 20) begin
      fails++;
      end_sim();
    end
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rcsr(input int e, input logic [31:0] m = 32'hFFFF_FFDF);
    apb(0, 12'h030 + 4 * e, 0);
    chk(r & m, (fl[e] | cf[e] | (tg[e] << 11) | (cn[e] << 16)) & m);
  endtask
  // flag bits written 1 are left alone, clr bits written 0
  task automatic wcsr(input int e, input int clr, input int set);
    fl[e] &= ~clr;
    if (set & 16) fl[e] |= 16;
    apb(1, 12'h030 + 4 * e, cf[e] | (32'h4F & ~clr) | set);
  endtask
  // registered pop: byte k shows on read k+1
  task automatic drain(input int e, input int n);
    for (int k = 0; k <= n; k++) begin
      if (k == n) begin
        cn[e] = 0;
        rcsr(e);
      end
      apb(0, 12'h050 + 4 * e, 0);
      if (k > 0) chk(r & 32'hFF, u_host.rxq[k-1]);
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'h1A1D3358));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rcsr(0);
    apb(0, 12'h100, 0);
    chk(r, 32'h0);
    for (int t = 0; t < 8; t++) if (t != 4) begin
      cf[1] = (t[0] ? 32'h8000 : 0) | (t << 8);
      wcsr(1, 0, 0);
      rcsr(1);
    end
    cf[1] = 32'h8100; cf[0] = 32'h8000; cf[2] = 32'h8200;
    for (int e = 0; e < 3; e++) wcsr(e, 0, 0);
    u_host.ev(4, 1); fl[1] |= 8;
    rcsr(1);
    u_host.out_pkt(0, 8, 1); fl[0] |= 4; cn[0] = 8;
    rcsr(0);
    chk({31'h0, out_accept[0]}, 0);
    u_host.out_pkt(0, 4, 0);
    rcsr(0);
    drain(0, 8);
    u_host.out_pkt(2, 3, 0); fl[2] |= 2; cn[2] = 3; tg[2] ^= 1;
    rcsr(2);
    drain(2, 3);
    apb(1, 12'h028, 5); apb(1, 12'h028, 0); tg[2] = 0;
    rcsr(0);
    rcsr(2);
    wcsr(2, 2, 0);
    u_host.out_pkt(2, 2, 0); fl[2] |= 64; cn[2] = 2; tg[2] ^= 1;
    rcsr(2);
    cf[0] |= 128;
    wcsr(0, 4, 0);
    repeat (5) begin
      wq.push_back($urandom);
      apb(1, 12'h050, wq[$]);
    end
    wcsr(0, 0, 16);
    chk({31'h0, in_ready[0]}, 1);
    u_host.in_pkt(0, 5); fl[0] = (fl[0] & ~16) | 1; tg[0] ^= 1;
    foreach (wq[k]) chk(u_host.txq[k], wq[k]);
    rcsr(0);
    chk({28'h0, ep_irq}, 32'h7);
    wcsr(0, 1, 0);
    chk({31'h0, ep_irq[0]}, 0);
    wcsr(0, 0, 32);
    chk({31'h0, stall_req[0]}, 1);
    u_host.ev(3, 0); fl[0] |= 8;
    rcsr(0);
    wcsr(0, 8, 0);
    rcsr(0);
    apb(1, 12'h074, 32'h100);
    chk({31'h0, transceiver_disable}, 1);
    apb(0, 12'h074, 0);
    chk(r, 32'h100);
    apb(1, 12'h074, 0);
    chk({31'h0, transceiver_disable}, 0);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_sim();
  end
endmodule // tb_top
